// >>> core/indication_map.vh
// register offsets, field positions, codes and reset values of the block
`ifndef INDICATION_MAP_VH
`define INDICATION_MAP_VH
`define OFS_BASIC_MODE 12'h004
`define OFS_STATUS 12'h010
`define OFS_IRQ_STAT 12'h014
`define OFS_IRQ_EN 12'h018
`define OFS_IRQ_CLR 12'h01C
`define OFS_SAP_CFG 12'h020
`define OFS_SAP_REPLY 12'h024
`define OFS_CONF_CFG 12'h028
`define OFS_IND_HDR0 12'h030
`define OFS_IND_HDR1 12'h034
`define OFS_IND_STAT 12'h038
`define MODE_RESET 8'h00
`define MODE_MONITOR 7
`define MODE_EARLY_RDY 6
`define MODE_INT_POL 5
`define MODE_SEP_INT 4
`define MODE_LIMIT_HI 3
`define MODE_LIMIT_LO 2
`define MODE_ACTIVE 1
`define MODE_NO_CTRL 0
`define IND_OK 8'h00
`define IND_BAD 8'hCF
`define CONF_SINGLE 5
`define EXT_BIT 8
`define LEN_MAX_SAP 8'hF4
`define LEN_MAX_NOSAP 8'hF6
`define IRQ_IND 0
`define IRQ_CONF 1
`define IRQ_BAD 2
`define IRQ_LEN_ERR 3
`endif

// >>> core/indication_block.v
// indication store, reply contract and basic mode register behind APB
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "indication_map.vh"
// What this block does
// - reply update pointer from the access point list goes into response header
// - each indication with access points is compared against the access point's configured values
// - indication status is 00 when valid and CF when invalid
// - confirmation status bit 5 set sends reply once, else every time
// - net payload length recorded, 0-244 with access points, else 0-246
// - source address to remote field, destination address to local field
// - only the low 4 bits of the function code are stored
// - access point numbers stored; valid only when extension bit 8 is set
// - mode bit 7 selects normal or bus monitor operation
// - mode bit 6 makes the host ready one cycle early
// - mode bit 5 sets interrupt pin polarity, 0 low, 1 high
// - mode bit 4 splits reply/indication events onto their own pin
// - mode bits 3:2 give highest station 0F, 1F, 3F or 7F
// - mode bit 1 selects passive or active token-holding station
// - mode bit 0 disables start and stop bit checks when set
module indication_block (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire online,
  input wire rx_valid,
  input wire [7:0] rx_len,
  input wire [8:0] rx_src_adr,
  input wire [8:0] rx_dst_adr,
  input wire [7:0] rx_fc,
  input wire [5:0] rx_rem_sap,
  input wire [5:0] rx_loc_sap,
  output reg tx_reply,
  output reg monitor_mode,
  output reg active_station,
  output reg [6:0] top_station_limit,
  output reg frame_check_off,
  output reg early_ready,
  output reg general_event_irq_pin,
  output reg reply_indication_irq_pin
);
  reg [7:0] basic_mode_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_en_reg;
  reg [5:0] sap_num_reg;
  reg sap_en_reg;
  reg [3:0] sap_fc_reg;
  reg [15:0] sap_reply_ptr_reg;
  reg sap_reply_en_reg;
  reg [7:0] conf_len_reg;
  reg [7:0] conf_status_reg;
  reg conf_armed_reg;
  reg [7:0] ind_len_reg;
  reg [8:0] ind_rem_adr_reg;
  reg [8:0] ind_loc_adr_reg;
  reg [3:0] ind_fc_reg;
  reg [5:0] ind_rem_sap_reg;
  reg [5:0] ind_loc_sap_reg;
  reg [7:0] ind_status_reg;
  reg [15:0] resp_buf_ptr_reg;
  reg rdy_wait_reg;
  wire wr_access;
  wire rd_setup;
  wire sap_used;
  wire ind_ok;
  wire len_ok;
  wire [3:0] ev_set;
  wire [3:0] pend;
  reg [31:0] rd_mux;
  reg rd_err;

  function [6:0] limit_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00: limit_decode = 7'h0F;
        2'b01: limit_decode = 7'h1F;
        2'b10: limit_decode = 7'h3F;
        default: limit_decode = 7'h7F;
      endcase
    end
  endfunction

  function known_addr;
    input [11:0] a;
    begin
      case (a)
        `OFS_BASIC_MODE, `OFS_STATUS, `OFS_IRQ_STAT, `OFS_IRQ_EN,
        `OFS_IRQ_CLR, `OFS_SAP_CFG, `OFS_SAP_REPLY, `OFS_CONF_CFG,
        `OFS_IND_HDR0, `OFS_IND_HDR1, `OFS_IND_STAT: known_addr = 1'b1;
        default: known_addr = 1'b0;
      endcase
    end
  endfunction

  // access completes when pready is high in the access phase
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  // access point in use when both address extension bits are set
  assign sap_used = rx_src_adr[`EXT_BIT] && rx_dst_adr[`EXT_BIT];
  assign len_ok = sap_used ? (rx_len <= `LEN_MAX_SAP) :
    (rx_len <= `LEN_MAX_NOSAP);
  // telegram with access points compared against the configured access point values
  assign ind_ok = len_ok && (!sap_used || (sap_en_reg &&
    rx_loc_sap == sap_num_reg && rx_fc[3:0] == sap_fc_reg));

  assign ev_set[`IRQ_IND] = rx_valid;
  assign ev_set[`IRQ_CONF] = rx_valid && ind_ok && conf_armed_reg;
  assign ev_set[`IRQ_BAD] = rx_valid && !ind_ok;
  assign ev_set[`IRQ_LEN_ERR] = rx_valid && !len_ok;
  assign pend = irq_stat_reg & irq_en_reg;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = !known_addr(paddr);
    case (paddr)
      `OFS_BASIC_MODE: rd_mux = {24'h00_0000, basic_mode_reg};
      `OFS_STATUS: rd_mux = {30'h0000_0000, conf_armed_reg, online};
      `OFS_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_reg};
      `OFS_IRQ_EN: rd_mux = {28'h000_0000, irq_en_reg};
      `OFS_SAP_CFG:
        rd_mux = {20'h0_0000, sap_fc_reg, sap_en_reg, sap_reply_en_reg,
          sap_num_reg};
      `OFS_SAP_REPLY: rd_mux = {16'h0000, sap_reply_ptr_reg};
      `OFS_CONF_CFG: rd_mux = {16'h0000, conf_status_reg, conf_len_reg};
      `OFS_IND_HDR0:
        rd_mux = {2'b00, ind_fc_reg, ind_loc_adr_reg, ind_rem_adr_reg,
          ind_len_reg};
      `OFS_IND_HDR1:
        rd_mux = {4'h0, resp_buf_ptr_reg, ind_loc_sap_reg, ind_rem_sap_reg};
      `OFS_IND_STAT: rd_mux = {24'h00_0000, ind_status_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb slave: normal ready one cycle into access, early ready at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rdy_wait_reg <= 1'b0;
    end else if (clk_en) begin
      if (psel && !pready && (basic_mode_reg[`MODE_EARLY_RDY] ?
          rd_setup : (penable && !rdy_wait_reg))) begin
        pready <= 1'b1;
        pslverr <= rd_err;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        rdy_wait_reg <= 1'b1;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        if (!psel || (penable && pready))
          rdy_wait_reg <= 1'b0;
      end
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_mode_reg <= `MODE_RESET;
      irq_en_reg <= 4'h0;
      sap_num_reg <= 6'h00;
      sap_en_reg <= 1'b0;
      sap_fc_reg <= 4'h0;
      sap_reply_en_reg <= 1'b0;
      sap_reply_ptr_reg <= 16'h0000;
      conf_len_reg <= 8'h00;
      conf_status_reg <= 8'h00;
    end else if (clk_en && wr_access) begin
      case (paddr)
        // basic mode writes while online are ignored
        `OFS_BASIC_MODE:
          if (!online)
            basic_mode_reg <= pwdata[7:0];
        `OFS_IRQ_EN: irq_en_reg <= pwdata[3:0];
        `OFS_SAP_CFG: begin
          sap_num_reg <= pwdata[5:0];
          sap_reply_en_reg <= pwdata[6];
          sap_en_reg <= pwdata[7];
          sap_fc_reg <= pwdata[11:8];
        end
        `OFS_SAP_REPLY: sap_reply_ptr_reg <= pwdata[15:0];
        `OFS_CONF_CFG: begin
          conf_len_reg <= pwdata[7:0];
          conf_status_reg <= pwdata[15:8];
        end
        default: sap_en_reg <= sap_en_reg;
      endcase
    end
  end

  // reply arming: a status write arms, single mode disarms after one reply
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conf_armed_reg <= 1'b0;
      tx_reply <= 1'b0;
    end else if (clk_en) begin
      tx_reply <= rx_valid && ind_ok && conf_armed_reg;
      if (wr_access && paddr == `OFS_CONF_CFG)
        conf_armed_reg <= 1'b1;
      else if (rx_valid && ind_ok && conf_armed_reg &&
          conf_status_reg[`CONF_SINGLE])
        conf_armed_reg <= 1'b0;
    end
  end

  // indication header capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_len_reg <= 8'h00;
      ind_rem_adr_reg <= 9'h000;
      ind_loc_adr_reg <= 9'h000;
      ind_fc_reg <= 4'h0;
      ind_rem_sap_reg <= 6'h00;
      ind_loc_sap_reg <= 6'h00;
      ind_status_reg <= `IND_OK;
      resp_buf_ptr_reg <= 16'h0000;
    end else if (clk_en && rx_valid) begin
      ind_len_reg <= rx_len;
      ind_rem_adr_reg <= rx_src_adr;
      ind_loc_adr_reg <= rx_dst_adr;
      ind_fc_reg <= rx_fc[3:0];
      ind_rem_sap_reg <= rx_rem_sap;
      ind_loc_sap_reg <= rx_loc_sap;
      ind_status_reg <= ind_ok ? `IND_OK : `IND_BAD;
      resp_buf_ptr_reg <= sap_reply_en_reg ? sap_reply_ptr_reg :
        16'h0000;
    end
  end

  // sticky events: set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat_reg <= 4'h0;
    else if (clk_en) begin
      if (wr_access && paddr == `OFS_IRQ_CLR)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | ev_set;
      else
        irq_stat_reg <= irq_stat_reg | ev_set;
    end
  end

  // mode decode and interrupt pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_mode <= 1'b0;
      early_ready <= 1'b0;
      active_station <= 1'b0;
      top_station_limit <= 7'h0F;
      frame_check_off <= 1'b0;
      general_event_irq_pin <= 1'b1;
      reply_indication_irq_pin <= 1'b1;
    end else if (clk_en) begin
      monitor_mode <= basic_mode_reg[`MODE_MONITOR];
      early_ready <= basic_mode_reg[`MODE_EARLY_RDY];
      active_station <= basic_mode_reg[`MODE_ACTIVE];
      top_station_limit <= limit_decode(
        basic_mode_reg[`MODE_LIMIT_HI:`MODE_LIMIT_LO]);
      frame_check_off <= basic_mode_reg[`MODE_NO_CTRL];
      if (basic_mode_reg[`MODE_SEP_INT]) begin
        general_event_irq_pin <= (|pend[3:2]) ~^
          basic_mode_reg[`MODE_INT_POL];
        reply_indication_irq_pin <= (|pend[1:0]) ~^
          basic_mode_reg[`MODE_INT_POL];
      end else begin
        general_event_irq_pin <= (|pend) ~^ basic_mode_reg[`MODE_INT_POL];
        reply_indication_irq_pin <= ~basic_mode_reg[`MODE_INT_POL];
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ind_props.sv
// checker on the ports of the indication block
`timescale 1ns/1ps
`default_nettype none
module ind_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic online,
  input wire logic rx_valid,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_reply,
  input wire logic monitor_mode,
  input wire logic early_ready,
  input wire logic active_station,
  input wire logic frame_check_off,
  input wire logic [6:0] top_station_limit
);
  logic [10:0] mode;
  assign mode = {monitor_mode, early_ready, active_station, frame_check_off,
    top_station_limit};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_NORMAL: assert property (
    psel && !penable && !early_ready && clk_en
    ##1 psel && penable && clk_en |-> !pready ##1 pready)
    else $error("normal ready not one cycle after access");
  AST_READY_EARLY: assert property (
    psel && !penable && early_ready && clk_en |=> pready)
    else $error("early ready missing at first access edge");
  AST_READY_IN_ACCESS: assert property (
    pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("slave error without ready");
  AST_REPLY_CAUSE: assert property (
    tx_reply |-> $past(rx_valid))
    else $error("reply without received indication");
  AST_LIMIT_CODE: assert property (
    top_station_limit inside {7'h0F, 7'h1F, 7'h3F, 7'h7F})
    else $error("station limit outside the four codes");
  AST_MODE_BY_WRITE: assert property (
    $changed(mode) |-> $past(psel) || $past(psel, 2))
    else $error("mode outputs changed without a bus write");
  AST_MODE_ONLINE: assert property (
    $past(online) && $past(online, 2) |-> $stable(mode))
    else $error("mode changed while online");
  cover property (rx_valid ##1 tx_reply);
  cover property (pslverr);
  cover property (early_ready && pready);
endmodule
bind indication_block ind_props u_props (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .online(online),
  .rx_valid(rx_valid), .pready(pready), .pslverr(pslverr),
  .tx_reply(tx_reply), .monitor_mode(monitor_mode),
  .early_ready(early_ready), .active_station(active_station),
  .frame_check_off(frame_check_off), .top_station_limit(top_station_limit));
`default_nettype wire

// >>> testbench/mac_model.sv
// receive side model that hands telegrams to the block
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_len,
  output logic [8:0] rx_src_adr,
  output logic [8:0] rx_dst_adr,
  output logic [7:0] rx_fc,
  output logic [5:0] rx_rem_sap,
  output logic [5:0] rx_loc_sap
);
  initial begin
    rx_valid = 1'b0;
    {rx_len, rx_src_adr, rx_dst_adr, rx_fc, rx_rem_sap, rx_loc_sap} = '0;
  end
  task send(input [7:0] l, input [8:0] s, input [8:0] d, input [7:0] f,
    input [5:0] rs, input [5:0] ls);
    @(posedge pclk);
    rx_valid <= 1'b1;
    {rx_len, rx_src_adr, rx_dst_adr, rx_fc, rx_rem_sap, rx_loc_sap} <=
      {l, s, d, f, rs, ls};
    @(posedge pclk);
    rx_valid <= 1'b0;
    // fields no longer qualified show the inverse
    {rx_len, rx_src_adr, rx_dst_adr, rx_fc, rx_rem_sap, rx_loc_sap} <=
      ~{l, s, d, f, rs, ls};
  endtask
endmodule
`default_nettype wire

// >>> testbench/indication_block_tb.sv
// self-checking bench of the indication block
`timescale 1ns/1ps
`default_nettype none
module indication_block_tb;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic online = 0, erv, rx_valid, tx_reply, mon, erd, act, nck, gpin, rpin;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr;
  logic [7:0] rx_len, rx_fc;
  logic [8:0] rx_src_adr, rx_dst_adr;
  logic [5:0] rx_rem_sap, rx_loc_sap;
  logic [6:0] lim;
  int miscompares = 0, check_count = 0, cyc = 0, txn = 0, t0;
  indication_block dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .online(online), .rx_valid(rx_valid), .rx_len(rx_len),
    .rx_src_adr(rx_src_adr), .rx_dst_adr(rx_dst_adr), .rx_fc(rx_fc),
    .rx_rem_sap(rx_rem_sap), .rx_loc_sap(rx_loc_sap), .tx_reply(tx_reply),
    .monitor_mode(mon), .active_station(act), .top_station_limit(lim),
    .frame_check_off(nck), .early_ready(erd), .general_event_irq_pin(gpin),
    .reply_indication_irq_pin(rpin));
  mac_model u_mac (.pclk(pclk), .rx_valid(rx_valid), .rx_len(rx_len),
    .rx_src_adr(rx_src_adr), .rx_dst_adr(rx_dst_adr), .rx_fc(rx_fc),
    .rx_rem_sap(rx_rem_sap), .rx_loc_sap(rx_loc_sap));
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (tx_reply === 1'b1) txn++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  task end_sim;
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task t_mode;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[0], i[0], 2'b00, i[1:0], i[0], i[0]};
      apb(1, 12'h004, v);
      apb(0, 12'h004, 0);
      chk(rdv, v);
      chk(lim, (8'h10 << i) - 1);
      chk({mon, erd, act, nck}, {4{i[0]}});
    end
    online <= 1'b1;
    apb(1, 12'h004, 8'h10);
    apb(0, 12'h004, 0);
    chk(rdv, 8'hCF);
    online <= 1'b0;
    apb(1, 12'h004, 8'h10);
    apb(0, 12'h0FC, 0);
    chk(erv, 1);
  endtask
  task t_ind;
    apb(1, 12'h018, 4'hF);
    apb(1, 12'h020, 32'h3C5);
    apb(1, 12'h024, 16'hABCD);
    apb(1, 12'h028, 32'h0810);
    t0 = txn;
    u_mac.send(8'h0A, 9'h105, 9'h107, 8'hF3, 6'd2, 6'd5);
    apb(0, 12'h030, 0);
    chk(rdv, {2'b0, 4'h3, 9'h107, 9'h105, 8'h0A});
    apb(0, 12'h034, 0);
    chk(rdv, {4'h0, 16'hABCD, 6'd5, 6'd2});
    apb(0, 12'h038, 0);
    chk(rdv, 8'h00);
    u_mac.send(8'h0A, 9'h105, 9'h107, 8'hF3, 6'd2, 6'd5);
    repeat (3) @(posedge pclk);
    chk(txn - t0, 2);
    chk({gpin, rpin}, 2'b10);
    apb(1, 12'h028, 32'h2810);
    t0 = txn;
    u_mac.send(8'hF5, 9'h105, 9'h107, 8'hF3, 6'd2, 6'd5);
    apb(0, 12'h038, 0);
    chk(rdv, 8'hCF);
    u_mac.send(8'h0A, 9'h105, 9'h107, 8'h04, 6'd2, 6'd5);
    apb(0, 12'h038, 0);
    chk(rdv, 8'hCF);
    u_mac.send(8'hF6, 9'h005, 9'h007, 8'hF3, 6'd2, 6'd5);
    apb(0, 12'h038, 0);
    chk(rdv, 8'h00);
    u_mac.send(8'h0A, 9'h105, 9'h107, 8'hF3, 6'd2, 6'd5);
    repeat (3) @(posedge pclk);
    chk(txn - t0, 1);
  endtask
  task t_irq;
    apb(1, 12'h01C, 4'hF);
    apb(0, 12'h014, 0);
    chk(rdv, 0);
    chk({gpin, rpin}, 2'b11);
    apb(1, 12'h018, 0);
    u_mac.send(8'h0A, 9'h105, 9'h107, 8'hF3, 6'd2, 6'd5);
    apb(0, 12'h014, 0);
    chk(rdv[0], 1);
    chk(rpin, 1);
    apb(1, 12'h004, 8'h20);
    apb(1, 12'h018, 4'hF);
    apb(0, 12'h004, 0);
    chk(gpin, 1);
    apb(1, 12'h01C, 4'hF);
    apb(0, 12'h004, 0);
    chk(gpin, 0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h004, 0);
    chk(rdv, 8'h00);
    chk({lim, gpin, rpin}, {7'h0F, 2'b11});
    t_mode;
    t_ind;
    t_irq;
    end_sim;
  end
endmodule
`default_nettype wire
